// ===== rtl/dcsi_irq.sv
// Top: two-channel interrupt priority, acknowledge and vector logic
`timescale 1ns/100ps
// Operation
// (RL1) Acknowledge picks highest eligible pending source
// (RL2) No-vector low drives programmed vector
// (RL3) No-vector high leaves data bus released
// (RL4) Status-in-vector substitutes three cause bits
// (RL5) Position select uses bits 1-3 or 4-6
// (RL6) Cause codes per channel; high placement reversed
// (RL7) Reset-highest command clears under-service flag
// (RL8) Chain disable forces chain output low
// (RL9) Two-bit field selects four receive modes
// (RL10) Data read pops data and status together
// (RL11) First-character mode interrupts once until rearmed
// (RL12) Special: overrun, framing, end of frame, parity
// (RL13) Special locks FIFO until error reset
// (RL14) Locked FIFO withholds receive DMA
// (RL15) Every-character mode pends on each character
// (RL16) Every-character mode never locks FIFO
// (RL17) Special-only mode pends only on specials
// (RL18) Receive causes share one flag pair
// (RL19) Transmit pends only on full-to-empty
// (RL20) End of CRC pends without buffer empty
// (RL21) Write or command clears transmit pending
// (RL22) Pending flags stay visible without master enable
// (RL23) Channel A above B; receive, transmit, status
// (RL24) Master enable off acts as chain input low
// (RL25) Pending or serviced source pulls chain output low; the code pulls it low for an enabled pending source only during acknowledge
// (RL26) Reset-highest clears only highest serviced flag
module dcsi_irq (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Configuration
  input wire dcsi_pkg::dcsi_ctrl_t ctrl_i,
  input wire logic [7:0] vector_register_i,
  input wire dcsi_pkg::dcsi_chmode_t mode_a_i,
  input wire dcsi_pkg::dcsi_chmode_t mode_b_i,
  input wire logic [2:0] source_enable_a_i,
  input wire logic [2:0] source_enable_b_i,
  // Channel events and commands
  input wire dcsi_pkg::dcsi_rxev_t rx_a_i,
  input wire dcsi_pkg::dcsi_rxev_t rx_b_i,
  input wire dcsi_pkg::dcsi_cmd_t cmd_a_i,
  input wire dcsi_pkg::dcsi_cmd_t cmd_b_i,
  input wire logic reset_highest_ius_i,
  // Daisy chain and acknowledge
  input wire logic chain_input_i,
  input wire logic irq_acknowledge_n_i,
  input wire logic vector_read_i,
  output logic chain_output_o,
  output logic irq_n_o,
  output logic irq_oe_n_o,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  // Status
  output logic [5:0] pending_flags_o,
  output logic [5:0] under_service_o,
  output logic [7:0] vector_readback_o,
  output logic [7:0] rx_data_a_o,
  output logic [3:0] rx_status_a_o,
  output logic [7:0] rx_data_b_o,
  output logic [3:0] rx_status_b_o,
  output logic [1:0] rx_avail_o,
  output logic [1:0] dma_req_o,
  output logic [1:0] tx_empty_o
);
  typedef struct packed {
    logic [5:0] under_service_flag;
    logic [7:0] dout;
    logic dout_en;
    logic irq;
  } dcsi_top_t;

  dcsi_top_t s_q, s_d;
  logic [5:0] ip;
  logic [5:0] ie;
  logic [1:0] rx_sp;
  logic [1:0] rxp;
  logic [1:0] txp;
  logic [1:0] esp;
  logic [5:0] sel;
  logic [5:0] clr;
  logic [5:0] req;
  logic [2:0] code;
  logic [7:0] vec;
  logic chain_en;
  logic blocked;
  logic ack;
  logic any_sel;

  dcsi_channel #(.DEPTH(dcsi_pkg::RX_DEPTH)) u_ch_a (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .mode_i(mode_a_i),
    .rx_i(rx_a_i),
    .cmd_i(cmd_a_i),
    .rx_pending_o(rxp[1]),
    .rx_special_o(rx_sp[1]),
    .tx_pending_o(txp[1]),
    .es_pending_o(esp[1]),
    .rx_data_o(rx_data_a_o),
    .rx_status_o(rx_status_a_o),
    .rx_avail_o(rx_avail_o[1]),
    .fifo_locked_o(),
    .dma_req_o(dma_req_o[1]),
    .tx_empty_o(tx_empty_o[1])
  );

  dcsi_channel #(.DEPTH(dcsi_pkg::RX_DEPTH)) u_ch_b (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .mode_i(mode_b_i),
    .rx_i(rx_b_i),
    .cmd_i(cmd_b_i),
    .rx_pending_o(rxp[0]),
    .rx_special_o(rx_sp[0]),
    .tx_pending_o(txp[0]),
    .es_pending_o(esp[0]),
    .rx_data_o(rx_data_b_o),
    .rx_status_o(rx_status_b_o),
    .rx_avail_o(rx_avail_o[0]),
    .fifo_locked_o(),
    .dma_req_o(dma_req_o[0]),
    .tx_empty_o(tx_empty_o[0])
  );

  // Priority order index 0 highest [RL23]
  assign ip = {esp[0], txp[0], rxp[0], esp[1], txp[1], rxp[1]};
  assign ie = {source_enable_b_i[2], source_enable_b_i[1],
               source_enable_b_i[0], source_enable_a_i[2],
               source_enable_a_i[1], source_enable_a_i[0]};
  // Pending flags readable regardless of master enable [RL22]
  assign pending_flags_o = ip;
  assign ack = !irq_acknowledge_n_i;
  // Master enable off equals chain input low [RL24]
  assign chain_en = chain_input_i && ctrl_i.master_interrupt_enable;

  always_comb begin
    sel = '0;
    clr = '0;
    req = '0;
    blocked = !chain_en;
    code = dcsi_pkg::ST_B_TX;
    any_sel = 1'b0;
    // Daisy walk; ius masks lower, ip gated in during acknowledge [RL1]
    for (int i = 0; i < dcsi_pkg::SRC_NUM; i++) begin
      if (!blocked && ip[i] && ie[i] && !s_q.under_service_flag[i]) begin
        sel[i] = ack;
        req[i] = 1'b1;
      end
      if (s_q.under_service_flag[i] || (ack && ip[i] && ie[i])) begin
        blocked = 1'b1;
      end
    end
    // Clear only the highest set under-service flag [RL26]
    for (int i = dcsi_pkg::SRC_NUM - 1; i >= 0; i--) begin
      if (s_q.under_service_flag[i]) begin
        clr = '0;
        clr[i] = 1'b1;
      end
    end
    // Cause of highest selected or pending source [RL6] [RL18]
    for (int i = dcsi_pkg::SRC_NUM - 1; i >= 0; i--) begin
      if (req[i]) begin
        any_sel = 1'b1;
      end
    end
    if (req[dcsi_pkg::SRC_ES_B]) code = dcsi_pkg::ST_B_ES;
    if (req[dcsi_pkg::SRC_TX_B]) code = dcsi_pkg::ST_B_TX;
    if (req[dcsi_pkg::SRC_RX_B]) begin
      code = rx_sp[0] ? dcsi_pkg::ST_B_SP : dcsi_pkg::ST_B_RX;
    end
    if (req[dcsi_pkg::SRC_ES_A]) code = dcsi_pkg::ST_A_ES;
    if (req[dcsi_pkg::SRC_TX_A]) code = dcsi_pkg::ST_A_TX;
    if (req[dcsi_pkg::SRC_RX_A]) begin
      code = rx_sp[1] ? dcsi_pkg::ST_A_SP : dcsi_pkg::ST_A_RX;
    end
    // Vector with optional status, low or reversed high [RL4] [RL5]
    vec = vector_register_i;
    if (ctrl_i.status_in_vector) begin
      if (ctrl_i.status_high) begin
        vec[6:4] = {code[0], code[1], code[2]};
      end else begin
        vec[3:1] = code;
      end
    end
    s_d = s_q;
    if (reset_highest_ius_i) begin
      s_d.under_service_flag = s_q.under_service_flag & ~clr; // [RL7]
    end
    s_d.dout_en = 1'b0;
    if (ack && vector_read_i && (|sel)) begin
      s_d.under_service_flag = s_d.under_service_flag | sel; // [RL1]
      s_d.dout = vec;
      s_d.dout_en = !ctrl_i.no_vector_select; // [RL2] [RL3]
    end
    s_d.irq = any_sel && !ack;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // Chain output: disable, serviced or acknowledged pending [RL8] [RL25]
  assign chain_output_o = chain_en && !ctrl_i.chain_disable &&
                          !(|s_q.under_service_flag) && !(ack && |(ip & ie));
  assign irq_n_o = 1'b0;
  assign irq_oe_n_o = !s_q.irq;
  assign data_o = s_q.dout;
  assign data_oe_n_o = !s_q.dout_en;
  assign under_service_o = s_q.under_service_flag;
  assign vector_readback_o = vec;

  property p_sel_one;
    @(posedge clock_i) disable iff (sys_rst_i)
      clk_en_i && ack && vector_read_i && (|sel) && !reset_highest_ius_i
      |=> $onehot(under_service_o & ~$past(under_service_o));
  endproperty
  a_sel_one: assert property (p_sel_one) // [RL1]
    else $error("acknowledge did not set exactly one flag");

  property p_nv_float;
    @(posedge clock_i) disable iff (sys_rst_i)
      clk_en_i && ctrl_i.no_vector_select |=> data_oe_n_o;
  endproperty
  a_nv_float: assert property (p_nv_float) // [RL3]
    else $error("bus driven with no-vector set");

  property p_vec_drive;
    @(posedge clock_i) disable iff (sys_rst_i)
      clk_en_i && ack && vector_read_i && (|sel) &&
      !ctrl_i.no_vector_select |=> !data_oe_n_o && data_o == $past(vec);
  endproperty
  a_vec_drive: assert property (p_vec_drive) // [RL2]
    else $error("vector not driven");

  property p_raw_vec;
    @(posedge clock_i) disable iff (sys_rst_i)
      !ctrl_i.status_in_vector |-> vector_readback_o == vector_register_i;
  endproperty
  a_raw_vec: assert property (p_raw_vec) // [RL4]
    else $error("vector modified without status");

  property p_dlc;
    @(posedge clock_i) disable iff (sys_rst_i)
      ctrl_i.chain_disable |-> !chain_output_o;
  endproperty
  a_dlc: assert property (p_dlc) // [RL8]
    else $error("chain output high while disabled");

  property p_mie;
    @(posedge clock_i) disable iff (sys_rst_i)
      clk_en_i && !ctrl_i.master_interrupt_enable |=> irq_oe_n_o;
  endproperty
  a_mie: assert property (p_mie) // [RL24]
    else $error("request with master enable off");

  property p_ius_chain;
    @(posedge clock_i) disable iff (sys_rst_i)
      (|under_service_o) |-> !chain_output_o;
  endproperty
  a_ius_chain: assert property (p_ius_chain) // [RL25]
    else $error("chain open while under service");

  property p_rst_one;
    @(posedge clock_i) disable iff (sys_rst_i)
      clk_en_i && reset_highest_ius_i && !(ack && vector_read_i) &&
      $countones(under_service_o) == 2
      |=> $countones(under_service_o) == 1;
  endproperty
  a_rst_one: assert property (p_rst_one) // [RL26]
    else $error("reset-highest cleared wrong count");

  c_ack: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    ack && vector_read_i && (|sel));
  c_two_ius: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    $countones(under_service_o) == 2);
  c_rst_ius: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    reset_highest_ius_i && (|under_service_o));
endmodule : dcsi_irq

// ===== rtl/dcsi_pkg.sv
// Package: shared types and constants for the serial interrupt logic
package dcsi_pkg;
  // Receive interrupt mode field position and codes
  localparam int RX_MODE_LSB = 3;
  localparam int RX_MODE_MSB = 4;
  localparam logic [1:0] RXM_OFF = 2'h0;
  localparam logic [1:0] RXM_FIRST = 2'h1;
  localparam logic [1:0] RXM_ALL = 2'h2;
  localparam logic [1:0] RXM_SPECIAL = 2'h3;
  // Receive data FIFO depth
  localparam int RX_DEPTH = 4;
  // Source indices, highest priority first
  localparam int SRC_NUM = 6;
  localparam int SRC_RX_A = 0;
  localparam int SRC_TX_A = 1;
  localparam int SRC_ES_A = 2;
  localparam int SRC_RX_B = 3;
  localparam int SRC_TX_B = 4;
  localparam int SRC_ES_B = 5;
  // Status codes placed in the vector
  localparam logic [2:0] ST_B_TX = 3'h0;
  localparam logic [2:0] ST_B_ES = 3'h1;
  localparam logic [2:0] ST_B_RX = 3'h2;
  localparam logic [2:0] ST_B_SP = 3'h3;
  localparam logic [2:0] ST_A_TX = 3'h4;
  localparam logic [2:0] ST_A_ES = 3'h5;
  localparam logic [2:0] ST_A_RX = 3'h6;
  localparam logic [2:0] ST_A_SP = 3'h7;
  // Reset values
  localparam logic [7:0] VECTOR_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;

  // Interrupt control settings
  typedef struct packed {
    logic master_interrupt_enable;
    logic chain_disable;
    logic no_vector_select;
    logic status_in_vector;
    logic status_high;
  } dcsi_ctrl_t;

  // Per channel mode settings
  typedef struct packed {
    logic [4:0] interrupt_mode_register;
    logic parity_special;
    logic es_enable;
  } dcsi_chmode_t;

  // Per channel receive event inputs
  typedef struct packed {
    logic char_valid;
    logic [7:0] char_data;
    logic overrun;
    logic framing;
    logic end_of_frame;
    logic parity;
    logic async_mode;
    logic sdlc_mode;
  } dcsi_rxev_t;

  // Per channel commands, each a one-cycle pulse
  typedef struct packed {
    logic data_read;
    logic enable_next_char;
    logic error_reset;
    logic tx_write;
    logic reset_tx_pending;
    logic tx_buffer_emptied;
    logic crc_done_flag_loaded;
    logic es_event;
    logic reset_es;
  } dcsi_cmd_t;
endpackage : dcsi_pkg

// ===== rtl/dcsi_channel.sv
// Receive and transmit pending logic for one channel
`timescale 1ns/100ps
module dcsi_channel #(
  parameter int DEPTH = dcsi_pkg::RX_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Settings and events
  input wire dcsi_pkg::dcsi_chmode_t mode_i,
  input wire dcsi_pkg::dcsi_rxev_t rx_i,
  input wire dcsi_pkg::dcsi_cmd_t cmd_i,
  // Results
  output logic rx_pending_o,
  output logic rx_special_o,
  output logic tx_pending_o,
  output logic es_pending_o,
  output logic [7:0] rx_data_o,
  output logic [3:0] rx_status_o,
  output logic rx_avail_o,
  output logic fifo_locked_o,
  output logic dma_req_o,
  output logic tx_empty_o
);
  if (DEPTH < 2 || DEPTH > 16) begin : g_depth_chk
    $error("DEPTH out of range");
  end
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][11:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
    logic first_armed;
    logic first_hit;
    logic locked;
    logic sp_done;
    logic tx_pend;
    logic tx_full;
    logic es_pend;
  } dcsi_ch_t;

  dcsi_ch_t s_q, s_d;
  logic [1:0] rxm;
  logic [3:0] in_st;
  logic in_sp;
  logic head_sp;
  logic pop;
  logic push;

  always_comb begin
    rxm = mode_i.interrupt_mode_register[dcsi_pkg::RX_MODE_MSB:
                                         dcsi_pkg::RX_MODE_LSB]; // [RL9]
    // Special: overrun, async framing, sdlc end of frame, opt parity [RL12]
    in_st = {rx_i.overrun, rx_i.framing & rx_i.async_mode,
             rx_i.end_of_frame & rx_i.sdlc_mode,
             rx_i.parity & mode_i.parity_special};
    in_sp = |in_st;
    head_sp = |s_q.mem[s_q.rd][3:0];
    // Pop data and status together [RL10]; locked FIFO holds head [RL13]
    pop = cmd_i.data_read && s_q.cnt != '0 && !s_q.locked;
    push = rx_i.char_valid;
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = {rx_i.char_data, in_st};
      s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
    end
    // Full FIFO overwrites last entry; overrun flags it
    if (push && !pop && s_q.cnt == (AW+1)'(DEPTH)) begin
      s_d.wr = s_q.wr;
      s_d.mem[(s_q.wr == '0) ? AW'(DEPTH - 1) : s_q.wr - 1'b1] =
        {rx_i.char_data, in_st | 4'h8};
      s_d.mem[s_q.wr] = s_q.mem[s_q.wr];
    end else if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    // First character mode arming [RL11]
    if (cmd_i.enable_next_char || rxm != dcsi_pkg::RXM_FIRST) begin
      s_d.first_armed = 1'b1;
      s_d.first_hit = 1'b0;
    end
    if (rxm == dcsi_pkg::RXM_FIRST && s_q.first_armed && s_q.cnt != '0) begin
      s_d.first_armed = 1'b0;
      s_d.first_hit = 1'b1;
    end
    if (s_q.first_hit && pop) begin
      s_d.first_hit = 1'b0;
    end
    // Lock on special head in first-char and special-only modes [RL13] [RL16]
    if (cmd_i.error_reset) begin
      s_d.locked = 1'b0;
      s_d.sp_done = s_q.locked;
    end
    // Serviced special head stays unlocked until popped
    if (pop) begin
      s_d.sp_done = 1'b0;
    end
    if (s_q.cnt != '0 && head_sp && !s_q.locked && !s_q.sp_done &&
        (rxm == dcsi_pkg::RXM_FIRST || rxm == dcsi_pkg::RXM_SPECIAL)) begin
      s_d.locked = 1'b1;
    end
    // Transmit pending: full to empty or end of CRC [RL19] [RL20]
    if (cmd_i.tx_write) begin
      s_d.tx_full = 1'b1;
    end
    if (cmd_i.tx_write || cmd_i.reset_tx_pending) begin
      s_d.tx_pend = 1'b0; // [RL21]
    end
    if (cmd_i.tx_buffer_emptied && s_q.tx_full) begin
      s_d.tx_full = 1'b0;
      s_d.tx_pend = mode_i.interrupt_mode_register[1];
    end
    if (cmd_i.crc_done_flag_loaded && mode_i.interrupt_mode_register[1]) begin
      s_d.tx_pend = 1'b1;
    end
    if (cmd_i.reset_es) begin
      s_d.es_pend = 1'b0;
    end
    if (cmd_i.es_event && mode_i.es_enable) begin
      s_d.es_pend = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.first_armed <= 1'b1;
      s_q.tx_full <= 1'b0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    rx_special_o = 1'b0;
    rx_pending_o = 1'b0;
    unique case (rxm)
      dcsi_pkg::RXM_OFF: rx_pending_o = 1'b0;
      // Special cause only while the locked head is read; the lock pends at once [RL13]
      dcsi_pkg::RXM_FIRST: begin
        rx_special_o = s_q.locked && cmd_i.data_read;
        rx_pending_o = s_q.first_hit || s_q.locked;
      end
      // Every character, shared flag [RL15] [RL18]
      dcsi_pkg::RXM_ALL: begin
        rx_special_o = s_q.cnt != '0 && head_sp;
        rx_pending_o = s_q.cnt != '0;
      end
      // Only special characters [RL17]
      dcsi_pkg::RXM_SPECIAL: begin
        rx_special_o = s_q.locked;
        rx_pending_o = s_q.locked;
      end
    endcase
  end

  assign tx_pending_o = s_q.tx_pend;
  assign es_pending_o = s_q.es_pend;
  assign rx_data_o = s_q.mem[s_q.rd][11:4];
  assign rx_status_o = s_q.mem[s_q.rd][3:0];
  assign rx_avail_o = s_q.cnt != '0;
  assign fifo_locked_o = s_q.locked;
  // No DMA while special locks FIFO [RL14]
  assign dma_req_o = s_q.cnt != '0 && !s_q.locked && !head_sp &&
                     rxm == dcsi_pkg::RXM_SPECIAL;
  assign tx_empty_o = !s_q.tx_full;

  property p_tx_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
      clk_en_i && cmd_i.tx_write && !cmd_i.crc_done_flag_loaded &&
      !cmd_i.tx_buffer_emptied |=> !tx_pending_o;
  endproperty
  a_tx_clear: assert property (p_tx_clear) // [RL21]
    else $error("tx pending not cleared by write");

  property p_no_dma_locked;
    @(posedge clock_i) disable iff (sys_rst_i)
      fifo_locked_o |-> !dma_req_o;
  endproperty
  a_no_dma_locked: assert property (p_no_dma_locked) // [RL14]
    else $error("dma while locked");

  property p_all_no_lock;
    @(posedge clock_i) disable iff (sys_rst_i)
      rxm == dcsi_pkg::RXM_ALL && !fifo_locked_o |=> !fifo_locked_o;
  endproperty
  a_all_no_lock: assert property (p_all_no_lock) // [RL16]
    else $error("lock in all-character mode");
endmodule : dcsi_channel

// ===== testbench/dcsi_host_model.sv
// Upstream chain neighbour and external vector source
`timescale 1ns/100ps
module dcsi_host_model (
  // Clock
  input wire logic clock_i,
  // Bench controls
  input wire logic upstream_busy_i,
  input wire logic ext_drive_i,
  input wire logic [7:0] ext_vector_i,
  // Device bus side
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_n_i,
  // Resolved levels
  output logic chain_input_o,
  output logic [7:0] bus_o
);
  logic [7:0] float_q = 8'h5a;

  // Busy higher device holds chain low
  assign chain_input_o = ~upstream_busy_i;

  // Released bus shows a changing pattern
  always_ff @(posedge clock_i) begin
    float_q <= ~float_q;
  end

  // External logic supplies vector when device floats
  assign bus_o = !dev_oe_n_i ? dev_data_i :
                 ext_drive_i ? ext_vector_i : float_q;
endmodule : dcsi_host_model

// ===== testbench/tb_top.sv
// Bench for the two-channel serial interrupt logic
`timescale 1ns/100ps
module tb_top;
  localparam int C_RD = 8;
  localparam int C_NXT = 7;
  localparam int C_ERR = 6;
  localparam int C_WR = 5;
  localparam int C_RTX = 4;
  localparam int C_EMP = 3;
  localparam int C_CRC = 2;
  localparam int C_ES = 1;
  localparam int C_RES = 0;
  localparam int C_RHI = 9;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  dcsi_pkg::dcsi_ctrl_t ctrl = 5'h12;
  logic [7:0] vec = 8'hf1;
  dcsi_pkg::dcsi_chmode_t mode_a = 7'h09;
  dcsi_pkg::dcsi_chmode_t mode_b = 7'h09;
  dcsi_pkg::dcsi_rxev_t rx_a = '0;
  dcsi_pkg::dcsi_rxev_t rx_b = '0;
  dcsi_pkg::dcsi_cmd_t cmd_a = '0;
  dcsi_pkg::dcsi_cmd_t cmd_b = '0;
  logic rhi = 1'b0;
  logic ack_n = 1'b1;
  logic vread = 1'b0;
  logic busy = 1'b0;
  logic ext_drive = 1'b0;
  logic [2:0] en_b = 3'h7;
  logic chain_in, chain_out, irq_n, irq_oe_n, data_oe_n;
  logic [7:0] data, bus, vrb, rxd_a, rxd_b, v;
  logic [3:0] rxs_a, rxs_b;
  logic [5:0] pend, under_service_flag;
  logic [1:0] avail, dma, txe;
  logic oe, co, ch, es;
  int miscompares = 0;
  int n_compared = 0;

  initial begin
    forever #10 clock_i = ~clock_i;
  end

  dcsi_host_model u_host (.clock_i(clock_i), .upstream_busy_i(busy),
    .ext_drive_i(ext_drive), .ext_vector_i(8'h3c), .dev_data_i(data),
    .dev_oe_n_i(data_oe_n), .chain_input_o(chain_in), .bus_o(bus));

  dcsi_irq u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1), .ctrl_i(ctrl), .vector_register_i(vec),
    .mode_a_i(mode_a), .mode_b_i(mode_b), .source_enable_a_i(3'h7),
    .source_enable_b_i(en_b), .rx_a_i(rx_a), .rx_b_i(rx_b),
    .cmd_a_i(cmd_a), .cmd_b_i(cmd_b), .reset_highest_ius_i(rhi),
    .chain_input_i(chain_in), .irq_acknowledge_n_i(ack_n),
    .vector_read_i(vread), .chain_output_o(chain_out), .irq_n_o(irq_n),
    .irq_oe_n_o(irq_oe_n), .data_o(data), .data_oe_n_o(data_oe_n),
    .pending_flags_o(pend), .under_service_o(under_service_flag),
    .vector_readback_o(vrb), .rx_data_a_o(rxd_a), .rx_status_a_o(rxs_a),
    .rx_data_b_o(rxd_b), .rx_status_b_o(rxs_b), .rx_avail_o(avail),
    .dma_req_o(dma), .tx_empty_o(txe));

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle();
    repeat (2) @(posedge clock_i);
    #1;
  endtask : settle

  task automatic cmd(input logic c_a, input int k);
    dcsi_pkg::dcsi_cmd_t c;
    c = '0;
    @(posedge clock_i);
    if (k == C_RHI) rhi <= 1'b1;
    else begin
      c[k] = 1'b1;
      if (c_a) cmd_a <= c;
      else cmd_b <= c;
    end
    @(posedge clock_i);
    rhi <= 1'b0;
    cmd_a <= '0;
    cmd_b <= '0;
    settle();
  endtask : cmd

  task automatic rxc(input logic [7:0] d, input logic [3:0] st);
    dcsi_pkg::dcsi_rxev_t r;
    r = '0;
    r.char_valid = 1'b1;
    r.char_data = d;
    {r.overrun, r.framing, r.end_of_frame, r.parity} = st;
    @(posedge clock_i);
    rx_a <= r;
    @(posedge clock_i);
    rx_a <= '0;
    settle();
  endtask : rxc

  task automatic ack();
    @(posedge clock_i);
    ack_n <= 1'b0;
    settle();
    co = chain_out;
    @(posedge clock_i);
    vread <= 1'b1;
    @(posedge clock_i);
    vread <= 1'b0;
    #1;
    v = bus;
    oe = data_oe_n;
    @(posedge clock_i);
    ack_n <= 1'b1;
    settle();
  endtask : ack

  task automatic setm(input logic [1:0] m);
    @(posedge clock_i);
    mode_a.interrupt_mode_register[4:3] <= m;
    settle();
  endtask : setm

  function automatic logic [7:0] xv(input logic [2:0] c);
    xv = vec;
    if (ctrl.status_in_vector && ctrl.status_high) begin
      xv[6:4] = {c[0], c[1], c[2]};
    end else if (ctrl.status_in_vector) begin
      xv[3:1] = c;
    end
  endfunction : xv

  task automatic complete_run();
    $display("Compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    #400_000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    settle();
    // Transmit pending
    cmd(1, C_EMP);
    chk("tx pend", 0, pend[1]);
    cmd(1, C_WR);
    cmd(1, C_EMP);
    chk("tx pend", 1, pend[1]);
    cmd(1, C_WR);
    chk("tx pend", 0, pend[1]);
    cmd(1, C_CRC);
    chk("tx pend", 1, pend[1]);
    chk("tx empty", 0, txe[1]);
    cmd(1, C_RTX);
    chk("tx pend", 0, pend[1]);
    $display("Done transmit");
    // Cause codes per transmit and status source of both channels
    for (int i = 0; i < 4; i++) begin
      ch = (i < 2);
      es = i[0];
      @(posedge clock_i);
      ctrl.status_high <= es;
      if (es) cmd(ch, C_ES);
      else begin
        cmd(ch, C_WR);
        cmd(ch, C_EMP);
      end
      chk("readback", xv({ch, 1'b0, es}), vrb);
      ack();
      chk("tx empty", 1, txe[ch]);
      chk("chain out", 0, co);
      chk("vector", xv({ch, 1'b0, es}), v);
      chk("ius", 1, under_service_flag[ch ? 1 + es : 4 + es]);
      cmd(ch, es ? C_RES : C_RTX);
      cmd(0, C_RHI);
      chk("ius", 0, under_service_flag);
    end
    $display("Done codes");
    // Priority and masking
    cmd(1, C_WR);
    cmd(1, C_EMP);
    cmd(0, C_WR);
    cmd(0, C_EMP);
    ack();
    chk("vector", xv(dcsi_pkg::ST_A_TX), v);
    cmd(1, C_RTX);
    ack();
    chk("bus off", 1, oe);
    cmd(0, C_RHI);
    ack();
    chk("vector", xv(dcsi_pkg::ST_B_TX), v);
    cmd(1, C_WR);
    cmd(1, C_EMP);
    ack();
    chk("ius", 8'h12, under_service_flag);
    cmd(0, C_RHI);
    chk("ius", 8'h10, under_service_flag);
    cmd(1, C_RTX);
    cmd(0, C_RHI);
    $display("Done priority");
    // Vector source selection
    @(posedge clock_i);
    ctrl.no_vector_select <= 1'b1;
    ext_drive <= 1'b1;
    ack();
    chk("bus", 8'h3c, v);
    chk("bus off", 1, oe);
    cmd(0, C_RHI);
    @(posedge clock_i);
    ctrl <= 5'h10;
    ext_drive <= 1'b0;
    ack();
    chk("vector", 8'hf1, v);
    cmd(0, C_RHI);
    $display("Done vector");
    // Master enable and chain control
    @(posedge clock_i);
    ctrl <= 5'h02;
    settle();
    chk("pending", 8'h10, pend);
    chk("request", 1, irq_oe_n);
    ack();
    chk("bus off", 1, oe);
    @(posedge clock_i);
    ctrl <= 5'h1a;
    settle();
    chk("request", 0, irq_oe_n);
    chk("irq level", 0, irq_n);
    chk("chain out", 0, chain_out);
    @(posedge clock_i);
    ctrl <= 5'h12;
    busy <= 1'b1;
    settle();
    chk("request", 1, irq_oe_n);
    chk("chain out", 0, chain_out);
    @(posedge clock_i);
    busy <= 1'b0;
    en_b <= 3'h5;
    settle();
    chk("request", 1, irq_oe_n);
    @(posedge clock_i);
    en_b <= 3'h7;
    cmd(0, C_RTX);
    chk("chain out", 1, chain_out);
    $display("Done chain");
    // Receive modes
    rxc(8'h41, 4'h0);
    chk("rx pend", 0, pend[0]);
    chk("rx data", 8'h41, rxd_a);
    cmd(1, C_RD);
    chk("avail", 0, avail[1]);
    setm(dcsi_pkg::RXM_ALL);
    rxc(8'h52, 4'h8);
    rxc(8'h53, 4'h0);
    ack();
    chk("vector", xv(dcsi_pkg::ST_A_SP), v);
    chk("rx status", 8'h08, rxs_a);
    cmd(1, C_RD);
    chk("rx data", 8'h53, rxd_a);
    chk("rx pend", 1, pend[0]);
    cmd(1, C_RD);
    chk("rx pend", 0, pend[0]);
    cmd(0, C_RHI);
    setm(dcsi_pkg::RXM_FIRST);
    rxc(8'h61, 4'h0);
    rxc(8'h62, 4'h0);
    ack();
    chk("vector", xv(dcsi_pkg::ST_A_RX), v);
    cmd(1, C_RD);
    chk("rx pend", 0, pend[0]);
    cmd(1, C_NXT);
    chk("rx pend", 1, pend[0]);
    cmd(1, C_RD);
    cmd(0, C_RHI);
    setm(dcsi_pkg::RXM_SPECIAL);
    rxc(8'h71, 4'h0);
    chk("rx pend", 0, pend[0]);
    chk("dma", 1, dma[1]);
    cmd(1, C_RD);
    rxc(8'h72, 4'h1);
    rxc(8'h73, 4'h4);
    chk("rx pend", 0, pend[0]);
    cmd(1, C_RD);
    cmd(1, C_RD);
    rxc(8'h74, 4'h8);
    chk("dma", 0, dma[1]);
    chk("rx pend", 1, pend[0]);
    cmd(1, C_RD);
    chk("rx data", 8'h74, rxd_a);
    cmd(1, C_ERR);
    cmd(1, C_RD);
    chk("avail", 0, avail[1]);
    @(posedge clock_i);
    rx_b.char_valid <= 1'b1;
    rx_b.char_data <= 8'h81;
    rx_b.overrun <= 1'b1;
    @(posedge clock_i);
    rx_b <= '0;
    settle();
    chk("rx data b", 8'h81, rxd_b);
    chk("rx status b", 8'h08, rxs_b);
    chk("rx pend b", 0, pend[3]);
    chk("dma b", 0, dma[0]);
    chk("avail b", 1, avail[0]);
    cmd(0, C_RD);
    chk("avail b", 0, avail[0]);
    $display("Done receive");
    complete_run();
  end
endmodule : tb_top
